// ---- rtl/adc_result_pkg.sv ----
`default_nettype none
package adc_result_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam int NUM_CH = 4;
    localparam int IRQ_W = 2 * NUM_CH;

    // lower result register layout
    localparam int LOW_RES_MSB = 7;
    localparam int LOW_RES_LSB = 6;
    localparam int LOW_ONES_MSB = 5;
    localparam int LOW_ONES_LSB = 2;
    localparam int LOW_OVR_BIT = 1;
    localparam int LOW_STORED_BIT = 0;
    localparam logic [3:0] LOW_ONES_VAL = 4'hf;
    // split of the 10-bit result between the two registers
    localparam int RES_LOW_BITS = 2;

    localparam logic [ADDR_W-1:0] CH1_RESULT_LOW_ADDR = 32'hffff_f302;
    localparam logic [ADDR_W-1:0] CH1_RESULT_HIGH_ADDR = 32'hffff_f303;
    localparam logic [ADDR_W-1:0] CH2_RESULT_LOW_ADDR = 32'hffff_f304;
    localparam logic [ADDR_W-1:0] CH2_RESULT_HIGH_ADDR = 32'hffff_f305;
    localparam logic [ADDR_W-1:0] CH3_RESULT_LOW_ADDR = 32'hffff_f306;
    localparam logic [ADDR_W-1:0] CH3_RESULT_HIGH_ADDR = 32'hffff_f307;
    localparam logic [ADDR_W-1:0] CH4_RESULT_LOW_ADDR = 32'hffff_f308;
    localparam logic [ADDR_W-1:0] CH4_RESULT_HIGH_ADDR = 32'hffff_f309;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 32'hffff_f3f0;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 32'hffff_f3f1;

    localparam logic [ADDR_W-1:0] LOW_ADDR [NUM_CH] = '{
        CH1_RESULT_LOW_ADDR, CH2_RESULT_LOW_ADDR, CH3_RESULT_LOW_ADDR, CH4_RESULT_LOW_ADDR};
    localparam logic [ADDR_W-1:0] HIGH_ADDR [NUM_CH] = '{
        CH1_RESULT_HIGH_ADDR, CH2_RESULT_HIGH_ADDR, CH3_RESULT_HIGH_ADDR, CH4_RESULT_HIGH_ADDR};

    localparam logic [DATA_W-1:0] RESULT_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
endpackage
`default_nettype wire

// ---- rtl/result_pair.sv ----
`timescale 1ns/100ps
`default_nettype none
module result_pair (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic store_i,
    input wire logic [adc_result_pkg::RES_W-1:0] result_i,
    input wire logic low_read_i,
    output logic [adc_result_pkg::DATA_W-1:0] low_byte_o,
    output logic [adc_result_pkg::DATA_W-1:0] high_byte_o,
    output logic overrun_event_o
);
    import adc_result_pkg::*;

    logic [RES_W-1:0] result;
    logic result_stored_flag;
    logic overrun_flag;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            result <= {RESULT_RESET, 2'h0};
        end else if (store_i) begin
            result <= result_i;
        end
    end

    // a read in the same cycle as a store returns the old value, so the
    // old value was consumed and no overrun is counted
    assign overrun_event_o = store_i && result_stored_flag && !low_read_i;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            result_stored_flag <= 1'h0;
        end else if (store_i) begin
            result_stored_flag <= 1'h1;
        end else if (low_read_i) begin
            result_stored_flag <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            overrun_flag <= 1'h0;
        end else if (overrun_event_o) begin
            overrun_flag <= 1'h1;
        end else if (low_read_i) begin
            overrun_flag <= 1'h0;
        end
    end

    always_comb begin
        low_byte_o = '0;
        low_byte_o[LOW_RES_MSB:LOW_RES_LSB] = result[RES_LOW_BITS-1:0];
        low_byte_o[LOW_ONES_MSB:LOW_ONES_LSB] = LOW_ONES_VAL;
        low_byte_o[LOW_OVR_BIT] = overrun_flag;
        low_byte_o[LOW_STORED_BIT] = result_stored_flag;
    end

    assign high_byte_o = result[RES_W-1:RES_LOW_BITS];
endmodule
`default_nettype wire

// ---- rtl/irq_status.sv ----
`timescale 1ns/100ps
`default_nettype none
module irq_status (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [adc_result_pkg::IRQ_W-1:0] event_i,
    input wire logic status_read_i,
    input wire logic mask_write_i,
    input wire logic [adc_result_pkg::IRQ_W-1:0] mask_wdata_i,
    output logic [adc_result_pkg::IRQ_W-1:0] status_o,
    output logic [adc_result_pkg::IRQ_W-1:0] mask_o,
    output logic irq_o
);
    import adc_result_pkg::*;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status_o <= '0;
        end else begin
            // an event in the clearing cycle survives the read
            status_o <= (status_read_i ? '0 : status_o) | event_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mask_o <= IRQ_MASK_RESET;
        end else if (mask_write_i) begin
            mask_o <= mask_wdata_i;
        end
    end

    assign irq_o = |(status_o & mask_o);
endmodule
`default_nettype wire

// ---- rtl/adc_result_bank.sv ----
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - result bits 1:0 appear in bits 7:6 of the channel's lower register
// - result bits 9:2 appear in bits 7:0 of the read-only upper register
// - lower register bit 1 is a read-only overrun flag, reset to 0
// - lower register bits 5:2 always read as ones
// - lower register bit 0 resets to 0, set when a new result is stored
// - reading the lower register clears the stored flag; upper read does not
module adc_result_bank (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [adc_result_pkg::ADDR_W-1:0] addr_i,
    input wire logic [adc_result_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [adc_result_pkg::DATA_W-1:0] rdata_o,
    input wire logic [adc_result_pkg::NUM_CH-1:0] store_i,
    input wire logic [adc_result_pkg::NUM_CH*adc_result_pkg::RES_W-1:0] result_i,
    output logic irq_o
);
    import adc_result_pkg::*;

    logic [NUM_CH-1:0] low_read;
    logic [NUM_CH-1:0] overrun_event;
    logic [DATA_W-1:0] low_byte [NUM_CH];
    logic [DATA_W-1:0] high_byte [NUM_CH];
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic status_read;
    logic mask_write;
    logic [DATA_W-1:0] next_rdata;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            result_pair u_pair (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .store_i(store_i[g]),
                .result_i(result_i[g*RES_W +: RES_W]),
                .low_read_i(low_read[g]),
                .low_byte_o(low_byte[g]),
                .high_byte_o(high_byte[g]),
                .overrun_event_o(overrun_event[g])
            );
        end
    endgenerate

    // only the lower register read clears the stored and overrun flags; upper reads have no side effect
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            low_read[i] = rd_i && (addr_i == LOW_ADDR[i]);
        end
    end

    assign status_read = rd_i && (addr_i == IRQ_STATUS_ADDR);
    assign mask_write = wr_i && (addr_i == IRQ_MASK_ADDR);

    irq_status u_irq (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .event_i({overrun_event, store_i}),
        .status_read_i(status_read),
        .mask_write_i(mask_write),
        .mask_wdata_i(wdata_i),
        .status_o(status),
        .mask_o(mask),
        .irq_o(irq_o)
    );

    // result registers ignore writes; unmapped reads return zero
    always_comb begin
        next_rdata = UNMAPPED_READ;
        if (rd_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr_i == LOW_ADDR[i]) begin
                    next_rdata = low_byte[i];
                end
                if (addr_i == HIGH_ADDR[i]) begin
                    next_rdata = high_byte[i];
                end
            end
            if (addr_i == IRQ_STATUS_ADDR) begin
                next_rdata = status;
            end
            if (addr_i == IRQ_MASK_ADDR) begin
                next_rdata = mask;
            end
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= UNMAPPED_READ;
        end else begin
            rdata_o <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ---- tb/adc_result_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_result_props
    import adc_result_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic [NUM_CH-1:0] store_i,
    input wire logic [NUM_CH*RES_W-1:0] result_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire logic l1 = rd_i && addr_i == CH1_RESULT_LOW_ADDR;
    wire logic h1 = rd_i && addr_i == CH1_RESULT_HIGH_ADDR;
    wire logic s1 = store_i[0];
    property p_res_lo; s1 ##1 l1 |=> rdata_o[7:6] == $past(result_i[1:0], 2); endproperty
    a_res_lo: assert property (p_res_lo) else $error("low result bits");
    property p_res_hi; s1 ##1 h1 |=> rdata_o == $past(result_i[9:2], 2); endproperty
    a_res_hi: assert property (p_res_hi) else $error("high result bits");
    property p_ones;
        rd_i && addr_i[31:4] == 28'hfff_ff30 && addr_i[3:0] inside {4'h2, 4'h4, 4'h6, 4'h8}
        |=> rdata_o[5:2] == 4'hf;
    endproperty
    a_ones: assert property (p_ones) else $error("ones field");
    property p_set; s1 ##1 l1 |=> rdata_o[0]; endproperty
    a_set: assert property (p_set) else $error("stored flag not set");
    property p_clr; (l1 && !s1) ##1 (l1 && !s1) |=> rdata_o[1:0] == 2'h0; endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared");
    property p_keep; s1 ##1 (h1 && !s1) ##1 l1 |=> rdata_o[0]; endproperty
    a_keep: assert property (p_keep) else $error("upper read cleared flag");
    property p_ovr; s1 ##1 (s1 && !l1) ##1 l1 |=> rdata_o[1]; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not set");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    import adc_result_pkg::*;
    logic ref_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [NUM_CH-1:0] store_i = '0;
    logic [NUM_CH*RES_W-1:0] result_i = '0;
    wire logic [DATA_W-1:0] rdata_o;
    wire logic irq_o;
    int mismatches = 0;
    int n_compared = 0;
    adc_result_bank u_adc_result_bank (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .store_i, .result_i, .irq_o);
    initial forever #20 ref_clk_i = ~ref_clk_i;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // every bus task is entered and left in the time step of a rising edge; the
    // idle edge at its end keeps one strobe from being assigned twice at once
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'h0;
        // data launched at the taking edge is sampled at the next edge, before it moves
        @(posedge ref_clk_i);
        chk("rdata_o", e, rdata_o);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'h0;
        @(posedge ref_clk_i);
    endtask
    task automatic st(input logic [3:0] m, input logic [9:0] v);
        store_i <= m;
        result_i <= 40'(v) << (RES_W * $clog2(m));
        @(posedge ref_clk_i);
        store_i <= '0;
        @(posedge ref_clk_i);
    endtask
    task automatic t_reset;
        for (int i = 0; i < NUM_CH; i++) begin
            rd(LOW_ADDR[i], 8'h3c);
        end
    endtask
    task automatic t_store;
        logic [9:0] v;
        for (int i = 0; i < NUM_CH; i++) begin
            v = 10'h2c5 + 10'(i * 3);
            st(4'(1 << i), v);
            rd(LOW_ADDR[i], {v[1:0], 6'h3d});
            rd(HIGH_ADDR[i], v[9:2]);
            rd(LOW_ADDR[i], {v[1:0], 6'h3c});
        end
    endtask
    task automatic t_ovr;
        wr(CH1_RESULT_LOW_ADDR, 8'h00);
        st(4'h1, 10'h155);
        st(4'h1, 10'h2aa);
        rd(CH1_RESULT_LOW_ADDR, 8'hbf);
        rd(CH1_RESULT_LOW_ADDR, 8'hbc);
        st(4'h1, 10'h0ff);
        rd(CH1_RESULT_HIGH_ADDR, 8'h3f);
        rd(CH1_RESULT_LOW_ADDR, 8'hfd);
    endtask
    // strobes with no gap; each read is judged at the edge after the one taking it
    task automatic t_b2b;
        store_i <= 4'h1;
        result_i <= 40'(10'h1e3);
        @(posedge ref_clk_i);
        result_i <= 40'(10'h21c);
        @(posedge ref_clk_i);
        store_i <= '0;
        rd_i <= 1'h1;
        addr_i <= CH1_RESULT_LOW_ADDR;
        @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        chk("rdata_o", 8'h3f, rdata_o);
        rd_i <= 1'h0;
        store_i <= 4'h1;
        result_i <= 40'(10'h2b6);
        @(posedge ref_clk_i);
        chk("rdata_o", 8'h3c, rdata_o);
        store_i <= '0;
        rd_i <= 1'h1;
        addr_i <= CH1_RESULT_HIGH_ADDR;
        @(posedge ref_clk_i);
        addr_i <= CH1_RESULT_LOW_ADDR;
        @(posedge ref_clk_i);
        chk("rdata_o", 8'had, rdata_o);
        rd_i <= 1'h0;
        store_i <= 4'h1;
        result_i <= 40'(10'h1e3);
        @(posedge ref_clk_i);
        chk("rdata_o", 8'hbd, rdata_o);
        // store and lower read together: old value read, flag stays, no overrun
        rd_i <= 1'h1;
        result_i <= 40'(10'h3a4);
        @(posedge ref_clk_i);
        store_i <= '0;
        @(posedge ref_clk_i);
        chk("rdata_o", 8'hfd, rdata_o);
        rd_i <= 1'h0;
        @(posedge ref_clk_i);
        chk("rdata_o", 8'h3d, rdata_o);
    endtask
    task automatic t_irq;
        chk("irq_o", 8'h00, 8'(irq_o));
        rd(IRQ_STATUS_ADDR, 8'h1f);
        wr(IRQ_MASK_ADDR, 8'hff);
        rd(IRQ_MASK_ADDR, 8'hff);
        st(4'h4, 10'h3ff);
        chk("irq_o", 8'h01, 8'(irq_o));
        rd(IRQ_STATUS_ADDR, 8'h04);
        chk("irq_o", 8'h00, 8'(irq_o));
        rd(32'hffff_f3ff, 8'h00);
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        @(posedge ref_clk_i);
        t_reset();
        t_store();
        t_ovr();
        t_b2b();
        t_irq();
        stop_test();
    end
    initial begin
        // the scenarios need under 100 cycles; this leaves a wide margin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule
bind adc_result_bank adc_result_props u_adc_result_props (.ref_clk_i, .rst_i, .addr_i,
    .rd_i, .rdata_o, .store_i, .result_i);
`default_nettype wire
